// ==== hdl/pdw_regs.sv ====
/*
 * Position-data registers rewritten by a write-multiple-registers query,
 * range checks, movement-start alarms and the individual zone output.
 * Assumes a framing layer on clk_i that strips the frame, checks LRC/CRC
 * and sends the header, then the data words, then an end strobe.
 */

// What this block does
// R1 - Speed holds 0.01 mm/s steps, 1 to 999999, two registers.
// R2 - Speed above the configured maximum raises an alarm at movement start.
// R3 - Individual zone works only while positioning, apart from parameter zones.
// R4 - Zone bit is on while current position lies between lower and upper.
// R5 - Zone boundaries are signed 0.01 mm positions, FFF0BDC1h to 000F423Fh.
// R6 - Master writes upper boundary strictly above lower to get zone output.
// R7 - Equal upper and lower boundaries disable the individual zone output.
// R8 - Acceleration is one register, 0.01G steps, 1 to 300.
// R9 - Deceleration is one register, 0.01G steps, 1 to 300.
// R10 - Acceleration above the configured maximum raises an alarm at start.
// R11 - Deceleration above the configured maximum raises an alarm at start.
// R12 - Push limit: 255 is 100 percent; 33h-B2h, or 33h-1FEh high force.
// R13 - A push limit write takes effect at once, even while pressing.
// R14 - Load threshold sets the judgment level; zero turns judgment off.
// R15 - Whole entry: function 10h, fifteen registers, byte count 1Eh.
// R16 - A 32-bit value spans two registers, upper word first.
// R17 - Success reply echoes address, function, start and count only.
// R18 - Slave address is axis plus one, 01h-10h; 00h is broadcast.
// R19 - A query with a check error gets no reply at all.
// R20 - A good query that cannot be processed gets an exception reply.
// R21 - An entry starts at 1000h plus sixteen times its position number.
// R22 - Zone bit stays off whenever no positioning is active.
// R23 - All writes of a query land before the acknowledge goes out.
module pdw_regs #(
  parameter int NUM_POS = 16,
  parameter bit HIGH_FORCE = 1'b0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Identity
  input wire logic [3:0] axis_number_i,
  // Decoded query from the framing layer
  input wire logic frm_start_i,
  input wire pdw_pkg::pdw_query_hdr_t frm_hdr_i,
  input wire logic frm_word_valid_i,
  input wire logic [15:0] frm_word_i,
  input wire logic frm_end_i,
  input wire logic frm_check_ok_i,
  // Reply to the framing layer
  output logic resp_valid_o,
  output pdw_pkg::pdw_resp_t resp_o,
  // Motion side
  input wire logic move_start_i,
  input wire logic [$clog2(NUM_POS)-1:0] move_pos_i,
  input wire logic positioning_active_i,
  input wire logic [31:0] current_pos_i,
  input wire logic [31:0] max_speed_i,
  input wire logic [15:0] max_accel_i,
  input wire logic [15:0] max_decel_i,
  input wire logic alarm_clr_i,
  // Results
  output logic [2:0] alarm_o,
  output logic zone_o,
  output logic [15:0] push_limit_o,
  output logic [15:0] load_threshold_o,
  output logic load_judge_en_o
);

  localparam int PIW = $clog2(NUM_POS);
  localparam int WORDS = NUM_POS << pdw_pkg::POS_STRIDE_LOG2;
  localparam logic [15:0] PUSH_MAX = HIGH_FORCE ? pdw_pkg::PUSH_MAX_HIGH : pdw_pkg::PUSH_MAX_STD;

  // ***************************
  // Storage and query state
  // ***************************
  logic [15:0] mem_q [WORDS];
  pdw_pkg::pdw_state_t state_q;
  pdw_pkg::pdw_query_hdr_t hdr_q;
  logic [15:0] stage_q [15];
  logic [14:0] stage_wr_q;
  logic [4:0] wcnt_q;
  pdw_pkg::pdw_resp_t resp_q;
  logic bcast_q;
  logic [PIW-1:0] act_pos_q;
  logic [2:0] alarm_q;
  logic zone_q;
  logic [15:0] push_q;
  logic [15:0] load_q;

  // ***************************
  // Address decode
  // ***************************
  logic [15:0] idx;
  logic [PIW-1:0] qpos;
  logic [3:0] qoff;
  logic [4:0] wslot;
  logic addr_ok;
  logic own_addr;
  logic is_bcast;
  logic [7:0] my_addr;

  assign my_addr = 8'({4'h0, axis_number_i}) + pdw_pkg::SLAVE_ADDR_STEP; // [R18]
  assign own_addr = hdr_q.slave_addr == my_addr;
  assign is_bcast = hdr_q.slave_addr == pdw_pkg::BCAST_ADDR; // [R18]
  assign idx = hdr_q.start_addr - pdw_pkg::POS_BASE; // [R21]
  assign qpos = idx[pdw_pkg::POS_STRIDE_LOG2 +: PIW];
  assign qoff = idx[3:0];
  assign wslot = {1'b0, qoff} + wcnt_q;
  // Offset +F is not a register, so a run may not reach it
  assign addr_ok = (hdr_q.start_addr >= pdw_pkg::POS_BASE) &&
                   (idx[15:4] < 12'(NUM_POS)) && (hdr_q.reg_count != 16'h0000) &&
                   (hdr_q.reg_count <= 16'(pdw_pkg::ENTRY_REGS)) &&
                   (({1'b0, qoff} + hdr_q.reg_count[4:0]) <= pdw_pkg::ENTRY_REGS); // [R20]

  // ***************************
  // Merged view: staged word or stored word
  // ***************************
  logic [15:0] merged [15];
  for (genvar g = 0; g < 15; g++) begin : g_merge
    assign merged[g] = stage_wr_q[g] ? stage_q[g] : mem_q[{qpos, 4'(g)}];
  end

  logic [31:0] m_speed;
  logic [31:0] m_zup;
  logic [31:0] m_zlo;
  logic val_ok;
  logic count_ok;
  assign m_speed = {merged[pdw_pkg::OFS_SPEED], merged[pdw_pkg::OFS_SPEED + 4'h1]}; // [R16]
  assign m_zup = {merged[pdw_pkg::OFS_ZONE_UP], merged[pdw_pkg::OFS_ZONE_UP + 4'h1]};
  assign m_zlo = {merged[pdw_pkg::OFS_ZONE_LO], merged[pdw_pkg::OFS_ZONE_LO + 4'h1]};

  // Only fields the query touched are judged; untouched ones may still be blank
  always_comb begin
    val_ok = 1'b1;
    if ((stage_wr_q[pdw_pkg::OFS_SPEED] || stage_wr_q[pdw_pkg::OFS_SPEED + 4'h1]) &&
        (m_speed < pdw_pkg::SPEED_MIN || m_speed > pdw_pkg::SPEED_MAX)) begin // [R1]
      val_ok = 1'b0;
    end
    if ((stage_wr_q[pdw_pkg::OFS_ZONE_UP] || stage_wr_q[pdw_pkg::OFS_ZONE_UP + 4'h1]) &&
        ($signed(m_zup) < $signed(pdw_pkg::ZONE_MIN) ||
         $signed(m_zup) > $signed(pdw_pkg::ZONE_MAX))) begin // [R5]
      val_ok = 1'b0;
    end
    if ((stage_wr_q[pdw_pkg::OFS_ZONE_LO] || stage_wr_q[pdw_pkg::OFS_ZONE_LO + 4'h1]) &&
        ($signed(m_zlo) < $signed(pdw_pkg::ZONE_MIN) ||
         $signed(m_zlo) > $signed(pdw_pkg::ZONE_MAX))) begin // [R5]
      val_ok = 1'b0;
    end
    if (stage_wr_q[pdw_pkg::OFS_ACCEL] && (merged[pdw_pkg::OFS_ACCEL] < pdw_pkg::ACC_MIN ||
        merged[pdw_pkg::OFS_ACCEL] > pdw_pkg::ACC_MAX)) begin // [R8]
      val_ok = 1'b0;
    end
    if (stage_wr_q[pdw_pkg::OFS_DECEL] && (merged[pdw_pkg::OFS_DECEL] < pdw_pkg::ACC_MIN ||
        merged[pdw_pkg::OFS_DECEL] > pdw_pkg::ACC_MAX)) begin // [R9]
      val_ok = 1'b0;
    end
    // Zero is allowed: plain positioning entries carry no push current
    if (stage_wr_q[pdw_pkg::OFS_PUSH] && merged[pdw_pkg::OFS_PUSH] != pdw_pkg::CURRENT_OFF &&
        (merged[pdw_pkg::OFS_PUSH] < pdw_pkg::PUSH_MIN ||
         merged[pdw_pkg::OFS_PUSH] > PUSH_MAX)) begin // [R12]
      val_ok = 1'b0;
    end
    if (stage_wr_q[pdw_pkg::OFS_LOAD] && merged[pdw_pkg::OFS_LOAD] > PUSH_MAX) begin // [R14]
      val_ok = 1'b0;
    end
  end

  assign count_ok = ({8'h00, hdr_q.byte_count} == {hdr_q.reg_count[14:0], 1'b0}) &&
                    ({11'h000, wcnt_q} == hdr_q.reg_count); // [R15]

  logic [7:0] exc_code;
  always_comb begin
    exc_code = 8'h00;
    if (hdr_q.func != pdw_pkg::FUNC_WRITE_MULTI) begin // [R20]
      exc_code = pdw_pkg::EXC_ILLEGAL_FUNC;
    end else if (!addr_ok) begin
      exc_code = pdw_pkg::EXC_ILLEGAL_ADDR;
    end else if (!count_ok || !val_ok) begin
      exc_code = pdw_pkg::EXC_ILLEGAL_VALUE;
    end
  end

  logic frame_done;
  assign frame_done = (state_q == pdw_pkg::PDW_ST_COLLECT) && frm_end_i;

  // ***************************
  // Query sequencer
  // ***************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= pdw_pkg::PDW_ST_IDLE;
    end else begin
      case (state_q)
        pdw_pkg::PDW_ST_IDLE: begin
          if (frm_start_i) begin
            state_q <= pdw_pkg::PDW_ST_COLLECT;
          end
        end
        pdw_pkg::PDW_ST_COLLECT: begin
          if (frm_end_i) begin
            if (!frm_check_ok_i || !(own_addr || is_bcast)) begin
              state_q <= pdw_pkg::PDW_ST_IDLE; // [R19]
            end else if (exc_code == 8'h00) begin
              state_q <= pdw_pkg::PDW_ST_APPLY;
            end else if (is_bcast) begin
              state_q <= pdw_pkg::PDW_ST_IDLE; // [R18]
            end else begin
              state_q <= pdw_pkg::PDW_ST_RESP; // [R20]
            end
          end
        end
        pdw_pkg::PDW_ST_APPLY: begin
          state_q <= bcast_q ? pdw_pkg::PDW_ST_IDLE : pdw_pkg::PDW_ST_RESP; // [R23]
        end
        pdw_pkg::PDW_ST_RESP: begin
          state_q <= pdw_pkg::PDW_ST_IDLE;
        end
        default: begin
          state_q <= pdw_pkg::PDW_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hdr_q <= '0;
      bcast_q <= 1'b0;
    end else if (frm_start_i && state_q == pdw_pkg::PDW_ST_IDLE) begin
      hdr_q <= frm_hdr_i;
      bcast_q <= frm_hdr_i.slave_addr == pdw_pkg::BCAST_ADDR;
    end
  end

  // ***************************
  // Staging of incoming words
  // ***************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wcnt_q <= 5'h00;
      stage_wr_q <= '0;
      for (int k = 0; k < 15; k++) begin
        stage_q[k] <= pdw_pkg::WORD_ZERO;
      end
    end else if (frm_start_i && state_q == pdw_pkg::PDW_ST_IDLE) begin
      wcnt_q <= 5'h00;
      stage_wr_q <= '0;
    end else if (frm_word_valid_i && state_q == pdw_pkg::PDW_ST_COLLECT) begin
      // Words arrive upper half first, so slot order is address order
      if (wcnt_q != 5'h1F) begin
        wcnt_q <= wcnt_q + 5'h01;
      end
      if (wslot < pdw_pkg::ENTRY_REGS && wcnt_q < hdr_q.reg_count[4:0]) begin // [R16]
        stage_q[wslot[3:0]] <= frm_word_i;
        stage_wr_q[wslot[3:0]] <= 1'b1;
      end
    end
  end

  // ***************************
  // Register array: all staged words land in one cycle
  // ***************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int k = 0; k < WORDS; k++) begin
        mem_q[k] <= pdw_pkg::WORD_ZERO;
      end
    end else if (state_q == pdw_pkg::PDW_ST_APPLY) begin
      for (int k = 0; k < 15; k++) begin
        if (stage_wr_q[k]) begin
          mem_q[{qpos, 4'(k)}] <= stage_q[k]; // [R23]
        end
      end
    end
  end

  // ***************************
  // Reply
  // ***************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      resp_q <= '0;
    end else if (frame_done) begin
      resp_q.slave_addr <= hdr_q.slave_addr; // [R17]
      resp_q.func <= (exc_code == 8'h00) ? hdr_q.func : (hdr_q.func | pdw_pkg::EXC_FLAG);
      resp_q.start_addr <= hdr_q.start_addr;
      resp_q.reg_count <= hdr_q.reg_count;
      resp_q.exception <= exc_code != 8'h00; // [R20]
      resp_q.exc_code <= exc_code;
    end
  end

  assign resp_valid_o = state_q == pdw_pkg::PDW_ST_RESP;
  assign resp_o = resp_q;

  // ***************************
  // Movement start alarms
  // ***************************
  logic [31:0] st_speed;
  assign st_speed = {mem_q[{move_pos_i, pdw_pkg::OFS_SPEED}],
                     mem_q[{move_pos_i, pdw_pkg::OFS_SPEED + 4'h1}]};

  // A new alarm in the clearing cycle survives the clear
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      alarm_q <= 3'b000;
    end else begin
      alarm_q[pdw_pkg::ALM_SPEED] <= (move_start_i && st_speed > max_speed_i) ||
                                     (alarm_q[pdw_pkg::ALM_SPEED] && !alarm_clr_i); // [R2]
      alarm_q[pdw_pkg::ALM_ACCEL] <= (move_start_i &&
                                      mem_q[{move_pos_i, pdw_pkg::OFS_ACCEL}] > max_accel_i) ||
                                     (alarm_q[pdw_pkg::ALM_ACCEL] && !alarm_clr_i); // [R10]
      alarm_q[pdw_pkg::ALM_DECEL] <= (move_start_i &&
                                      mem_q[{move_pos_i, pdw_pkg::OFS_DECEL}] > max_decel_i) ||
                                     (alarm_q[pdw_pkg::ALM_DECEL] && !alarm_clr_i); // [R11]
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      act_pos_q <= '0;
    end else if (move_start_i) begin
      act_pos_q <= move_pos_i;
    end
  end

  // ***************************
  // Zone output and live current settings
  // ***************************
  logic [31:0] a_zup;
  logic [31:0] a_zlo;
  assign a_zup = {mem_q[{act_pos_q, pdw_pkg::OFS_ZONE_UP}],
                  mem_q[{act_pos_q, pdw_pkg::OFS_ZONE_UP + 4'h1}]};
  assign a_zlo = {mem_q[{act_pos_q, pdw_pkg::OFS_ZONE_LO}],
                  mem_q[{act_pos_q, pdw_pkg::OFS_ZONE_LO + 4'h1}]};

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      zone_q <= 1'b0;
    end else begin
      // Upper at or below lower is a master error; the bit simply stays off
      zone_q <= positioning_active_i && (a_zup != a_zlo) && // [R3] [R22] [R7] [R6]
                $signed(current_pos_i) >= $signed(a_zlo) &&
                $signed(current_pos_i) <= $signed(a_zup); // [R4]
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      push_q <= pdw_pkg::CURRENT_OFF;
      load_q <= pdw_pkg::CURRENT_OFF;
    end else begin
      push_q <= mem_q[{act_pos_q, pdw_pkg::OFS_PUSH}]; // [R13]
      load_q <= mem_q[{act_pos_q, pdw_pkg::OFS_LOAD}];
    end
  end

  assign alarm_o = alarm_q;
  assign zone_o = zone_q;
  assign push_limit_o = push_q;
  assign load_threshold_o = load_q;
  assign load_judge_en_o = load_q != pdw_pkg::CURRENT_OFF; // [R14]

  // ***************************
  // Checks
  // ***************************
  sequence s_bad_check;
    frame_done && !frm_check_ok_i;
  endsequence
  sequence s_bad_func;
    frame_done && frm_check_ok_i && own_addr && !is_bcast &&
    hdr_q.func != pdw_pkg::FUNC_WRITE_MULTI;
  endsequence

  AST_SILENT_ON_CHECK_ERR: assert property (@(posedge clk_i) disable iff (rst_i) // [R19]
    s_bad_check |=> !resp_valid_o [*3]) else $error("reply sent after check error");
  AST_EXC_ON_BAD_FUNC: assert property (@(posedge clk_i) disable iff (rst_i) // [R20]
    s_bad_func |=> resp_valid_o && resp_o.exception &&
    resp_o.exc_code == pdw_pkg::EXC_ILLEGAL_FUNC) else $error("no exception for bad function");
  AST_ACK_ECHO: assert property (@(posedge clk_i) disable iff (rst_i) // [R17]
    resp_valid_o && !resp_o.exception |-> resp_o.func == pdw_pkg::FUNC_WRITE_MULTI &&
    resp_o.slave_addr == my_addr && resp_o.start_addr == hdr_q.start_addr)
    else $error("acknowledge does not echo query");
  AST_APPLY_BEFORE_ACK: assert property (@(posedge clk_i) disable iff (rst_i) // [R23]
    resp_valid_o && !resp_o.exception |-> $past(state_q) == pdw_pkg::PDW_ST_APPLY)
    else $error("acknowledge without prior write");
  AST_BCAST_NO_REPLY: assert property (@(posedge clk_i) disable iff (rst_i) // [R18]
    frame_done && is_bcast |=> !resp_valid_o ##1 !resp_valid_o)
    else $error("reply to broadcast");
  AST_ZONE_IDLE_OFF: assert property (@(posedge clk_i) disable iff (rst_i) // [R22]
    !positioning_active_i |=> !zone_o) else $error("zone on while idle");
  AST_ZONE_EQUAL_OFF: assert property (@(posedge clk_i) disable iff (rst_i) // [R7]
    a_zup == a_zlo |=> !zone_o) else $error("zone on with equal boundaries");
  AST_ZONE_INSIDE: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
    positioning_active_i && $signed(a_zlo) < $signed(current_pos_i) &&
    $signed(current_pos_i) < $signed(a_zup) |=> zone_o) else $error("zone off inside band");
  AST_SPEED_ALARM: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
    move_start_i && st_speed > max_speed_i |=> alarm_o[pdw_pkg::ALM_SPEED])
    else $error("speed alarm missing");
  AST_ACCEL_ALARM: assert property (@(posedge clk_i) disable iff (rst_i) // [R10]
    move_start_i && mem_q[{move_pos_i, pdw_pkg::OFS_ACCEL}] > max_accel_i |=>
    alarm_o[pdw_pkg::ALM_ACCEL]) else $error("acceleration alarm missing");
  AST_DECEL_ALARM: assert property (@(posedge clk_i) disable iff (rst_i) // [R11]
    move_start_i && mem_q[{move_pos_i, pdw_pkg::OFS_DECEL}] > max_decel_i |=>
    alarm_o[pdw_pkg::ALM_DECEL]) else $error("deceleration alarm missing");
  AST_PUSH_LIVE: assert property (@(posedge clk_i) disable iff (rst_i) // [R13]
    state_q == pdw_pkg::PDW_ST_APPLY && qpos == act_pos_q && stage_wr_q[pdw_pkg::OFS_PUSH]
    && !move_start_i |=> ##1 push_limit_o == $past(stage_q[pdw_pkg::OFS_PUSH], 2))
    else $error("push limit not applied at once");

endmodule : pdw_regs

// ==== hdl/pdw_pkg.sv ====
/*
 * Constants, field layouts, states and carriers for the position-data write block.
 * Assumes a framing layer that checks the ASCII frame and hands over decoded fields.
 */
package pdw_pkg;

  // ***************************
  // Query codes and addresses
  // ***************************
  localparam logic [7:0] FUNC_WRITE_MULTI = 8'h10;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] BCAST_ADDR = 8'h00;
  localparam logic [7:0] SLAVE_ADDR_STEP = 8'h01;
  localparam logic [7:0] EXC_ILLEGAL_FUNC = 8'h01;
  localparam logic [7:0] EXC_ILLEGAL_ADDR = 8'h02;
  localparam logic [7:0] EXC_ILLEGAL_VALUE = 8'h03;
  localparam logic [15:0] POS_BASE = 16'h1000;
  localparam int POS_STRIDE_LOG2 = 4;
  localparam logic [4:0] ENTRY_REGS = 5'h0F;

  // ***************************
  // Word offsets inside one entry
  // ***************************
  localparam logic [3:0] OFS_SPEED = 4'h4;
  localparam logic [3:0] OFS_ZONE_UP = 4'h6;
  localparam logic [3:0] OFS_ZONE_LO = 4'h8;
  localparam logic [3:0] OFS_ACCEL = 4'hA;
  localparam logic [3:0] OFS_DECEL = 4'hB;
  localparam logic [3:0] OFS_PUSH = 4'hC;
  localparam logic [3:0] OFS_LOAD = 4'hD;

  // ***************************
  // Value ranges
  // ***************************
  localparam logic [31:0] SPEED_MIN = 32'h0000_0001;
  localparam logic [31:0] SPEED_MAX = 32'h000F_423F;
  localparam logic [31:0] ZONE_MIN = 32'hFFF0_BDC1;
  localparam logic [31:0] ZONE_MAX = 32'h000F_423F;
  localparam logic [15:0] ACC_MIN = 16'h0001;
  localparam logic [15:0] ACC_MAX = 16'h012C;
  localparam logic [15:0] PUSH_MIN = 16'h0033;
  localparam logic [15:0] PUSH_MAX_STD = 16'h00B2;
  localparam logic [15:0] PUSH_MAX_HIGH = 16'h01FE;
  localparam logic [15:0] CURRENT_OFF = 16'h0000;
  localparam logic [15:0] WORD_ZERO = 16'h0000;

  // ***************************
  // Alarm bit positions
  // ***************************
  localparam int ALM_SPEED = 0;
  localparam int ALM_ACCEL = 1;
  localparam int ALM_DECEL = 2;

  typedef enum logic [1:0] {
    PDW_ST_IDLE = 2'b00,
    PDW_ST_COLLECT = 2'b01,
    PDW_ST_APPLY = 2'b10,
    PDW_ST_RESP = 2'b11
  } pdw_state_t;

  typedef struct packed {
    logic [7:0] slave_addr;
    logic [7:0] func;
    logic [15:0] start_addr;
    logic [15:0] reg_count;
    logic [7:0] byte_count;
  } pdw_query_hdr_t;

  typedef struct packed {
    logic [7:0] slave_addr;
    logic [7:0] func;
    logic [15:0] start_addr;
    logic [15:0] reg_count;
    logic exception;
    logic [7:0] exc_code;
  } pdw_resp_t;

endpackage : pdw_pkg

// ==== sim/pdw_master_model.sv ====
/*
 * Behavioural master: sends decoded write queries to the block.
 * Assumes the bench calls send_query for one query at a time on clk_i.
 */
module pdw_master_model (
  // Clock
  input wire logic clk_i,
  // Decoded query towards the block
  output logic frm_start_o,
  output pdw_pkg::pdw_query_hdr_t frm_hdr_o,
  output logic frm_word_valid_o,
  output logic [15:0] frm_word_o,
  output logic frm_end_o,
  output logic frm_check_ok_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    frm_start_o = 1'b0;
    frm_hdr_o = '0;
    frm_word_valid_o = 1'b0;
    frm_word_o = 16'h0000;
    frm_end_o = 1'b0;
    frm_check_ok_o = 1'b0;
  end

  // Released lines carry inverted junk so stale values are never trusted
  task automatic send_query(input pdw_pkg::pdw_query_hdr_t hdr, input logic [15:0] w[$],
                            input logic ok);
    @(posedge clk_i);
    #1;
    frm_start_o = 1'b1;
    frm_hdr_o = hdr;
    foreach (w[k]) begin
      @(posedge clk_i);
      #1;
      frm_start_o = 1'b0;
      frm_hdr_o = ~hdr;
      frm_word_valid_o = 1'b1;
      frm_word_o = w[k];
    end
    @(posedge clk_i);
    #1;
    frm_start_o = 1'b0;
    frm_hdr_o = ~hdr;
    frm_word_valid_o = 1'b0;
    frm_word_o = ~frm_word_o;
    frm_end_o = 1'b1;
    frm_check_ok_o = ok;
    @(posedge clk_i);
    #1;
    frm_end_o = 1'b0;
    frm_check_ok_o = ~ok;
  endtask : send_query
endmodule : pdw_master_model

// ==== sim/pdw_regs_bench.sv ====
/*
 * Self-checking bench for pdw_regs: queries, alarms, zone and limits.
 * Assumes axis 0 (own address 01h), then axis 1 (02h) for the last query, NUM_POS 16 and standard push range.
 */
module pdw_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;

  // ***************************
  // Signals and instances
  // ***************************
  logic clk_i, rst_i, fs, fv, fe, fok, rv, ms, pa, aclr, zone_o, le;
  logic [3:0] axis_i, mp;
  pdw_pkg::pdw_query_hdr_t fh;
  pdw_pkg::pdw_resp_t resp_o;
  logic [15:0] fw, mxa, mxd, push_o, load_o;
  logic [31:0] cp, mxs;
  logic [2:0] alarm_o;
  logic [15:0] w[$];
  int mismatches = 0;
  int compares = 0;
  logic [15:0] bad_st[4] = '{16'h10C4, 16'h10CA, 16'h10CA, 16'h10CC};
  logic [31:0] bad_v[4] = '{32'h000F_4240, 32'h012D_001E, 32'h0001_012D, 32'h00B3_0000};

  pdw_master_model master (.clk_i(clk_i), .frm_start_o(fs), .frm_hdr_o(fh),
    .frm_word_valid_o(fv), .frm_word_o(fw), .frm_end_o(fe), .frm_check_ok_o(fok));

  pdw_regs #(.NUM_POS(16), .HIGH_FORCE(1'b0)) dut (.clk_i(clk_i), .rst_i(rst_i),
    .axis_number_i(axis_i), .frm_start_i(fs), .frm_hdr_i(fh), .frm_word_valid_i(fv),
    .frm_word_i(fw), .frm_end_i(fe), .frm_check_ok_i(fok), .resp_valid_o(rv),
    .resp_o(resp_o), .move_start_i(ms), .move_pos_i(mp), .positioning_active_i(pa),
    .current_pos_i(cp), .max_speed_i(mxs), .max_accel_i(mxa), .max_decel_i(mxd),
    .alarm_clr_i(aclr), .alarm_o(alarm_o), .zone_o(zone_o), .push_limit_o(push_o),
    .load_threshold_o(load_o), .load_judge_en_o(le));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // ***************************
  // Tasks
  // ***************************
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize

  task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick

  // Kind 0 ack, 1 exception with code, 2 no reply at all
  task automatic query(input logic [7:0] a, input logic [7:0] f, input logic [15:0] st,
                       input logic ok, input int kind, input logic [7:0] code);
    pdw_pkg::pdw_query_hdr_t hdr;
    logic seen;
    hdr = '{a, f, st, 16'(w.size()), 8'(2 * w.size())};
    seen = 1'b0;
    master.send_query(hdr, w, ok);
    for (int i = 0; i < 5 && !seen; i++) begin
      if (rv === 1'b1) seen = 1'b1;
      else tick(1);
    end
    if (kind == 2) begin
      check(64'(seen), 64'h0, "silent query");
    end else if (seen !== 1'b1) begin
      mismatches++;
      $display("mismatch at %0t: no reply", $time);
      summarize();
    end else if (kind == 0) begin
      check(64'({resp_o.slave_addr, resp_o.func, resp_o.start_addr, resp_o.reg_count,
        resp_o.exception}), 64'({a, f, st, hdr.reg_count, 1'b0}), "ack");
    end else begin
      check(64'({resp_o.func, resp_o.exception, resp_o.exc_code}),
        64'({f | 8'h80, 1'b1, code}), "exception");
    end
  endtask : query

  task automatic mv(input logic [3:0] p);
    @(posedge clk_i);
    #1;
    ms = 1'b1;
    mp = p;
    tick(1);
    ms = 1'b0;
    mp = ~p;
  endtask : mv

  // ***************************
  // Tests
  // ***************************
  initial begin
    rst_i = 1'b1;
    {axis_i, ms, mp, pa, cp, aclr} = '0;
    mxs = 32'h0000_4E20;
    mxa = 16'h0001;
    mxd = 16'h001E;
    repeat (5) @(posedge clk_i);
    #1;
    check(64'({rv, alarm_o, zone_o, push_o, le}), 64'h0, "reset outputs");
    rst_i = 1'b0;
    $display("test reset done");
    w = {16'h0000, 16'h2710, 16'h0000, 16'h000A, 16'h0000, 16'h4E20, 16'h0000, 16'h1770,
         16'h0000, 16'h0FA0, 16'h0001, 16'h001E, 16'h0000, 16'h0000, 16'h0000};
    query(8'h01, 8'h10, 16'h10C0, 1'b1, 0, 8'h00);
    pa = 1'b1;
    cp = 32'h0000_1388;
    mv(4'hC);
    tick(2);
    check(64'(zone_o), 64'h1, "zone inside");
    check(64'({push_o, le}), 64'h0, "push and judge off");
    cp = 32'h0000_1771;
    tick(2);
    check(64'(zone_o), 64'h0, "zone above");
    cp = 32'h0000_1388;
    pa = 1'b0;
    tick(2);
    check(64'(zone_o), 64'h0, "zone idle");
    $display("test full entry done");
    for (int i = 0; i < 3; i++) begin
      mxs = (i == 0) ? 32'h0000_4E1F : 32'h0000_4E20;
      mxa = (i == 1) ? 16'h0000 : 16'h0001;
      mxd = (i == 2) ? 16'h001D : 16'h001E;
      aclr = 1'b1;
      tick(1);
      aclr = 1'b0;
      mv(4'hC);
      tick(2);
      check(64'(alarm_o), 64'h1 << i, "alarm");
    end
    $display("test alarms done");
    pa = 1'b1;
    w = {16'h0000, 16'h1770, 16'h0000, 16'h1770};
    query(8'h01, 8'h10, 16'h10C6, 1'b1, 0, 8'h00);
    cp = 32'h0000_1770;
    tick(3);
    check(64'(zone_o), 64'h0, "equal bounds");
    w = {16'hFFF0, 16'hBDC1};
    query(8'h01, 8'h10, 16'h10C8, 1'b1, 0, 8'h00);
    cp = 32'hFFFF_FFF6;
    tick(3);
    check(64'(zone_o), 64'h1, "negative inside");
    $display("test zone done");
    w = {16'h00B2, 16'h0020};
    query(8'h01, 8'h10, 16'h10CC, 1'b1, 0, 8'h00);
    tick(3);
    check(64'({push_o, load_o, le}), 64'({16'h00B2, 16'h0020, 1'b1}), "limits");
    for (int i = 0; i < 4; i++) begin
      w = {bad_v[i][31:16], bad_v[i][15:0]};
      query(8'h01, 8'h10, bad_st[i], 1'b1, 1, 8'h03);
    end
    tick(3);
    check(64'(push_o), 64'h00B2, "refused write");
    $display("test ranges done");
    w = {16'h0001};
    query(8'h01, 8'h03, 16'h10CA, 1'b1, 1, 8'h01);
    query(8'h01, 8'h10, 16'h0FFF, 1'b1, 1, 8'h02);
    w = {16'h0050};
    query(8'h01, 8'h10, 16'h10CC, 1'b0, 2, 8'h00);
    w = {16'h0060};
    query(8'h02, 8'h10, 16'h10CC, 1'b1, 2, 8'h00);
    w = {16'h0040};
    query(8'h00, 8'h10, 16'h10CC, 1'b1, 2, 8'h00);
    tick(3);
    check(64'(push_o), 64'h0040, "only broadcast applied");
    // Own address must follow the axis number, not stay at 01h
    axis_i = 4'h1;
    w = {16'h0050};
    query(8'h02, 8'h10, 16'h10CC, 1'b1, 0, 8'h00);
    tick(3);
    check(64'(push_o), 64'h0050, "second axis address");
    $display("test exceptions done");
    summarize();
  end
endmodule : pdw_regs_bench
